// File: hw/lit_rot_core.sv
// Executes literal return and rotate left through carry
module lit_rot_core
	import lit_rot_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Decoded instruction
	input  wire logic        instrValid,
	input  wire instr_t      instr,
	// Data file read port, same clock
	input  wire logic [7:0]  fileRdData,
	output logic      [6:0]  fileRdAddr,
	// Hardware stack
	input  wire logic [14:0] stackTop,
	output logic             stackPop,
	// Architectural state
	output logic      [7:0]  accQ,
	output logic             carryQ,
	output logic      [14:0] pcQ,
	output fwrite_t          fileWr,
	// Sequencing
	output logic             busy,
	output logic             instrDone
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_POP  = 2'b10
	} state_t;

	state_t      stateQ;
	logic [7:0]  rotRes;
	logic        rotCarry;
	logic        takeRet;
	logic        takeRot;
	logic [1:0]  retCountQ;

	// Acceptance test shared by both kinds; the busy cycle drops anything offered
	function automatic logic accepts(input logic valid, input logic isBusy, input op_t op,
			input op_t want);
		return valid && !isBusy && (op == want);
	endfunction

	// Read port follows the instruction so the operand is there in the same cycle
	assign fileRdAddr = instr.fileAddr;
	assign busy       = (stateQ == S_POP);
	assign takeRet    = accepts(instrValid, busy, instr.op, OP_RETLIT);
	assign takeRot    = accepts(instrValid, busy, instr.op, OP_ROTL);
	// Pop in second cycle so stack top is stable during the first
	assign stackPop   = busy;
	assign instrDone  = busy || takeRot;

	rot_left_unit rotor (
		.src     (fileRdData),
		.carryIn (carryQ),
		.result  (rotRes),
		.carryOut(rotCarry)
	);

	// Two-cycle sequencer; rotate never leaves idle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			stateQ <= S_IDLE;
		end else begin
			case (stateQ)
				S_IDLE:  if (takeRet) stateQ <= S_POP;
				S_POP:   stateQ <= S_IDLE;
				default: stateQ <= S_IDLE;
			endcase
		end
	end

	// Accumulator
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			accQ <= ACC_RESET;
		end else if (takeRet) begin
			accQ <= instr.literal;
		end else if (takeRot && !instr.toSource) begin
			accQ <= rotRes;
		end
	end

	// Carry: only flag touched here
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			carryQ <= CARRY_RESET;
		end else if (takeRot) begin
			carryQ <= rotCarry;
		end
	end

	// Program counter loads return address on the pop cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pcQ <= PC_RESET;
		end else if (busy) begin
			pcQ <= stackTop;
		end
	end

	// Write-back to source location, registered
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fileWr <= '0;
		end else begin
			fileWr.en   <= takeRot && instr.toSource;
			fileWr.addr <= instr.fileAddr;
			fileWr.data <= rotRes;
		end
	end

	// Cycle count of the current return; only the length check reads it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			retCountQ <= 2'h0;
		end else if (takeRet) begin
			retCountQ <= 2'h1;
		end else if (busy) begin
			retCountQ <= 2'h2;
		end else begin
			retCountQ <= 2'h0;
		end
	end

	// Checks: each one names the rule whose behaviour it pins down

	// Return spends exactly one extra cycle busy
	property ret_two_p;
		@(posedge clock) disable iff (sys_rst)
		takeRet |=> busy ##1 !busy;
	endproperty
	retTwo_a: assert property (ret_two_p) else $error("return not two cycles");

	// Counted length of a return matches the cycle figure
	retLen_a: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(busy) |-> retCountQ == 2'(RETURN_CYCLES))
		else $error("return length wrong");

	// Completion shows only in the second cycle of a return
	retDone_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRet |-> !instrDone ##1 instrDone)
		else $error("return completion misplaced");

	// Literal reaches the accumulator
	retLit_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRet |=> accQ == $past(instr.literal))
		else $error("literal not loaded");

	// Return address comes from the stack top while popping
	retPc_a: assert property (@(posedge clock) disable iff (sys_rst)
		busy |=> pcQ == $past(stackTop))
		else $error("pc not from stack top");

	// Program counter moves only at the end of a pop
	pcHold_a: assert property (@(posedge clock) disable iff (sys_rst)
		!busy |=> pcQ == $past(pcQ))
		else $error("pc moved outside a pop");

	// Pop request lasts one cycle, or the stack would lose a second entry
	popPulse_a: assert property (@(posedge clock) disable iff (sys_rst)
		stackPop |=> !stackPop)
		else $error("pop longer than one cycle");

	// Anything offered during the busy cycle leaves state alone
	busyDrop_a: assert property (@(posedge clock) disable iff (sys_rst)
		busy |=> accQ == $past(accQ) && carryQ == $past(carryQ) && !fileWr.en)
		else $error("op taken while busy");

	// Old top bit becomes carry
	rotCarry_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRot |=> carryQ == $past(fileRdData[7]))
		else $error("carry wrong");

	// Return leaves carry alone
	carryHold_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRet |=> carryQ == $past(carryQ))
		else $error("return touched carry");

	// Nothing but a rotate moves carry
	carryOnly_a: assert property (@(posedge clock) disable iff (sys_rst)
		!takeRot |=> carryQ == $past(carryQ))
		else $error("carry moved without rotate");

	// Target select zero lands the result in the accumulator
	rotAcc_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRot && !instr.toSource |=> accQ == {$past(fileRdData[6:0]), $past(carryQ)})
		else $error("rotate acc result wrong");

	// Target select one writes back and spares the accumulator
	rotFile_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRot && instr.toSource |=> fileWr.en && accQ == $past(accQ))
		else $error("rotate write-back wrong");

	// Write-back carries the rotated byte to the source address
	rotData_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRot && instr.toSource |=> fileWr.data == {$past(fileRdData[6:0]), $past(carryQ)}
			&& fileWr.addr == $past(instr.fileAddr))
		else $error("write-back data wrong");

	// No write-back without a rotate aimed at its source
	wrOnly_a: assert property (@(posedge clock) disable iff (sys_rst)
		!(takeRot && instr.toSource) |=> !fileWr.en)
		else $error("stray write-back");

	// Accumulator moves only for a return or a rotate aimed at it
	accOnly_a: assert property (@(posedge clock) disable iff (sys_rst)
		!takeRet && !(takeRot && !instr.toSource) |=> accQ == $past(accQ))
		else $error("accumulator moved");

	// Rotate completes in its own cycle
	rotOne_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRot |-> instrDone && !stackPop)
		else $error("rotate not single cycle");

	// No stall after a rotate, so the next one can follow at once
	rotNoStall_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeRot |=> !busy)
		else $error("rotate stalled");

	// Main scenarios seen at least once
	retCov_c: cover property (@(posedge clock) takeRet);
	rotAccCov_c: cover property (@(posedge clock) takeRot && !instr.toSource);
	rotSrcCov_c: cover property (@(posedge clock) takeRot && instr.toSource);
	rotBackCov_c: cover property (@(posedge clock) takeRot ##1 takeRot);
	retDropCov_c: cover property (@(posedge clock) busy && instrValid && instr.op != OP_NONE);
endmodule

// File: hw/lit_rot_pkg.sv
// Overview of operation
// - Literal return loads immediate byte into accumulator
// - Literal return pops stack top; two cycles
// - Rotate left through carry; carry and the target (accumulator or source) change
// - Target select zero: accumulator; one: source
package lit_rot_pkg;
	localparam int DATA_W       = 8;
	localparam int PC_W         = 15;
	localparam int FADDR_W      = 7;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic       CARRY_RESET = 1'b0;
	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam int RETURN_CYCLES = 2;

	// Operation selector from the wider decoder
	typedef enum logic [2:0] {
		OP_NONE   = 3'b001,
		OP_RETLIT = 3'b010,
		OP_ROTL   = 3'b100
	} op_t;

	// One decoded instruction word
	typedef struct packed {
		op_t              op;
		logic [7:0]       literal;
		logic [6:0]       fileAddr;
		logic             toSource;
	} instr_t;

	// Write toward the data file
	typedef struct packed {
		logic             en;
		logic [6:0]       addr;
		logic [7:0]       data;
	} fwrite_t;
endpackage

// File: hw/rot_left_unit.sv
// Combinational rotate left through carry
module rot_left_unit
	import lit_rot_pkg::*;
(
	// Operand and carry in
	input  wire logic [7:0] src,
	input  wire logic       carryIn,
	// Result and carry out
	output logic      [7:0] result,
	output logic            carryOut
);
	// Old carry fills bit 0, old top bit leaves as carry
	always_comb begin
		result   = {src[6:0], carryIn};
		carryOut = src[7];
	end
endmodule

// File: testbench/literal_return_and_rotate_ops_tb.sv
module literal_return_and_rotate_ops_tb
	import lit_rot_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus and observed ports
	logic        clock = 0, sys_rst = 1, instrValid = 0;
	instr_t      instr;
	logic [7:0]  fileRdData, accQ;
	logic [6:0]  fileRdAddr;
	logic [14:0] stackTop, pcQ;
	logic        stackPop, carryQ, busy, instrDone;
	fwrite_t     fileWr;
	int          mismatches = 0, n_tests = 0;
	// Reference model: accumulator, carry, program counter, pending return addresses
	int          acc = 0, cy = 0, pc = 0, v, r, sel;
	int          retQueue[$];
	logic [31:0] rnd;

	always #5 clock = ~clock;

	lit_rot_core i_dut (.clock, .sys_rst, .instrValid, .instr, .fileRdData, .fileRdAddr,
		.stackTop, .stackPop, .accQ, .carryQ, .pcQ, .fileWr, .busy, .instrDone);

	// One line per mismatch
	task automatic fail(input string m);
		mismatches++;
		$display("wrong value at %0t: %s", $time, m);
	endtask

	// Accumulator against the model
	task automatic chk_acc(input int exp, input string m);
		n_tests++;
		if (accQ !== 8'(exp)) fail(m);
	endtask

	// Carry flag against the model
	task automatic chk_carry(input int exp, input string m);
		n_tests++;
		if (carryQ !== 1'(exp)) fail(m);
	endtask

	// Program counter against the model
	task automatic chk_pc(input int exp, input string m);
		n_tests++;
		if (pcQ !== 15'(exp)) fail(m);
	endtask

	// Write-back port; address and data only count while enabled
	task automatic chk_wr(input logic en, input logic [6:0] a, input int d, input string m);
		n_tests++;
		if (fileWr.en !== en || (en && (fileWr.addr !== a || fileWr.data !== 8'(d)))) fail(m);
	endtask

	// Sequencing flags, plus the read address that must follow the instruction
	task automatic chk_ctrl(input logic b, input logic p, input logic d, input string m);
		n_tests++;
		if (busy !== b || stackPop !== p || instrDone !== d || fileRdAddr !== instr.fileAddr)
			fail(m);
	endtask

	task finish_test;
		$display("mismatches %0d of %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Hang guard: the run needs about 400 cycles, 5000 are far out of reach
	initial begin
		#50000;
		mismatches++;
		finish_test;
	end

	// Reset held 16 cycles; every state output must show its reset value
	task automatic do_reset;
		instrValid = 1'b0;
		sys_rst = 1'b1;
		repeat (16) @(negedge clock);
		chk_acc(ACC_RESET, "reset acc");
		chk_carry(CARRY_RESET, "reset carry");
		chk_pc(PC_RESET, "reset pc");
		chk_wr(1'b0, 7'h00, 0, "reset write");
		chk_ctrl(1'b0, 1'b0, 1'b0, "reset flags");
		sys_rst = 1'b0;
		acc = ACC_RESET;
		cy = CARRY_RESET;
		pc = PC_RESET;
		retQueue.delete();
	endtask

	// One random operation per pass, each result held against the model
	task automatic run_ops(input int count);
		for (int i = 0; i < count; i++) begin
			rnd = $urandom;
			sel = $urandom % 3;
			stackTop = 15'($urandom);
			fileRdData = rnd[23:16];
			v = fileRdData;
			if (sel == 0) begin
				// Rotate: flags at once, carry and result at the next edge
				instrValid = 1'b1;
				instr = '{OP_ROTL, rnd[15:8], rnd[7:1], rnd[0]};
				#1;
				chk_ctrl(1'b0, 1'b0, 1'b1, "rotate same cycle");
				r = ((v << 1) | cy) & 255;
				cy = v >> 7;
				if (!instr.toSource) acc = r;
				@(negedge clock);
				chk_carry(cy, "rotate carry");
				chk_wr(instr.toSource, instr.fileAddr, r, "rotate write-back");
				chk_acc(acc, "rotate acc");
				chk_pc(pc, "rotate pc");
			end else if (sel == 1) begin
				// Return: literal at once, pop and address load in the busy cycle
				instrValid = 1'b1;
				instr = '{OP_RETLIT, rnd[15:8], rnd[7:1], rnd[0]};
				retQueue.push_back(stackTop);
				acc = instr.literal;
				@(negedge clock);
				chk_acc(acc, "literal");
				chk_ctrl(1'b1, 1'b1, 1'b1, "second cycle");
				// Rotate offered while busy, aimed at the source so a slip would show
				instr = '{OP_ROTL, instr.literal, instr.fileAddr, 1'b1};
				@(negedge clock);
				pc = retQueue.pop_front();
				chk_pc(pc, "pc");
				// The still-offered rotate is now visible as accepted
				chk_ctrl(1'b0, 1'b0, 1'b1, "busy end");
				chk_acc(acc, "ignored op acc");
				chk_carry(cy, "ignored op carry");
				chk_wr(1'b0, 7'h00, 0, "ignored op write");
			end else begin
				// Nothing valid offered: no state may move
				instrValid = rnd[24];
				instr = '{(rnd[24] ? OP_NONE : OP_ROTL), rnd[15:8], rnd[7:1], 1'b1};
				#1;
				chk_ctrl(1'b0, 1'b0, 1'b0, "idle flags");
				@(negedge clock);
				chk_acc(acc, "idle acc");
				chk_carry(cy, "idle carry");
				chk_wr(1'b0, 7'h00, 0, "idle write");
				chk_pc(pc, "idle pc");
			end
		end
	endtask

	// Reset, random mix, then a reset in mid-run and a shorter mix after it
	initial begin
		instr = '{OP_NONE, 8'h00, 7'h00, 1'b0};
		fileRdData = 8'h00;
		stackTop = 15'h0000;
		void'($urandom(32'he196));
		do_reset;
		$display("reset test done");
		run_ops(200);
		$display("random op test done");
		do_reset;
		run_ops(20);
		$display("mid-run reset test done");
		finish_test;
	end
endmodule
